// ---- shared/qpd_pkg.sv ----
// Types shared by the quadrature decoder
package qpd_pkg;
  typedef logic [31:0] qpd_word_t;
  typedef logic [5:0] qpd_ofs_t;
  typedef enum {QPD_IDLE, QPD_SERVICE} qpd_svc_t;
endpackage : qpd_pkg

// ---- shared/qpd_regs.svh ----
// Register offsets, field values and timing counts of the quadrature decoder
`ifndef QPD_REGS_SVH
`define QPD_REGS_SVH
`define QPD_OFS_ENABLE 6'h00
`define QPD_OFS_SELECT 6'h04
`define QPD_OFS_OPTIONS 6'h08
`define QPD_OFS_REF_CTRL 6'h0C
`define QPD_OFS_REF_LINE 6'h10
`define QPD_OFS_SPARE_C 6'h14
`define QPD_OFS_SPARE_D 6'h18
`define QPD_OFS_COUNT 6'h1C
`define QPD_OFS_ERRORS 6'h20
`define QPD_OFS_COUNT_F 6'h24
`define QPD_OFS_COUNT_RC 6'h28
`define QPD_OFS_UPPER 6'h2C
`define QPD_LINE_BIT 6
`define QPD_FEATURE_QUAD 32'h0000000A
`define QPD_REF_OFF 2'h0
`define QPD_REF_CONT 2'h1
`define QPD_REF_ONESHOT 2'h3
`define QPD_SERVICE_NS 14000
`define QPD_CLK_MHZ 250
`define QPD_SERVICE_CYC ((`QPD_SERVICE_NS * `QPD_CLK_MHZ) / 1000)
`define QPD_RST_WORD 32'h00000000
`endif

// ---- verif/qpd_encoder_model.sv ----
// Encoder model driving phase A, phase B and the reference line
`timescale 1ns/10ps
module qpd_encoder_model #(
  parameter int REF_LINE = 5
) (
  input wire logic i_clk,
  output logic [7:0] o_lines
);
  logic [1:0] pos = 2'h0;
  logic [1:0] gray [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  initial o_lines = 8'h00;
  // Gap is the caller's choice; a short one breaks the edge rate on purpose
  task automatic step(input logic up, input int gap);
    @(posedge i_clk);
    pos = up ? pos + 2'h1 : pos - 2'h1;
    o_lines[6] <= gray[pos][1];
    o_lines[7] <= gray[pos][0];
    repeat (gap) @(posedge i_clk);
  endtask : step
  // Activity on lines outside the pair and the reference
  task automatic noise(input logic [4:0] v);
    @(posedge i_clk);
    o_lines[4:0] <= v;
  endtask : noise
  task automatic set_ref(input logic lvl);
    @(posedge i_clk);
    o_lines[REF_LINE] <= lvl;
  endtask : set_ref
endmodule : qpd_encoder_model

// ---- verif/qpd_top_assertions.sv ----
// Port checker for the quadrature decoder top
`timescale 1ns/10ps
`include "qpd_regs.svh"
module qpd_top_assertions #(
  parameter int NUM_LINES = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [NUM_LINES-1:0] i_lines,
  input wire logic [7:0] i_addr,
  input wire qpd_pkg::qpd_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire qpd_pkg::qpd_word_t o_rdata,
  input wire logic i_stream_active,
  input wire logic i_stream_rd,
  input wire qpd_pkg::qpd_ofs_t i_stream_ofs,
  input wire logic [15:0] o_stream_data,
  input wire logic [15:0] o_stream_upper,
  input wire logic o_active
);
  import qpd_pkg::*;
  wire logic rd_odd = i_rd && i_addr[`QPD_LINE_BIT];
  wire logic rd_even = i_rd && !i_addr[`QPD_LINE_BIT];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_dual_count;
    rd_even && i_addr[5:0] == `QPD_OFS_COUNT && i_stream_rd && i_stream_ofs == `QPD_OFS_COUNT;
  endsequence
  sequence s_disable_write;
    i_wr && i_addr[5:0] == `QPD_OFS_ENABLE && !i_wdata[0];
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == '0) else $error("read data not idle");
  a_stream_idle: assert property (!i_stream_rd |=> o_stream_data == '0) else $error("stream data not idle");
  a_upper_hold: assert property (!i_stream_rd |=> $stable(o_stream_upper)) else $error("upper half moved");
  a_odd_results: assert property (rd_odd && i_addr[5:0] inside {`QPD_OFS_COUNT, `QPD_OFS_ERRORS,
    `QPD_OFS_COUNT_F, `QPD_OFS_COUNT_RC} |=> o_rdata == '0) else $error("odd result not zero");
  a_enable_bit: assert property (i_rd && i_addr[5:0] == `QPD_OFS_ENABLE |=> o_rdata[31:1] == '0)
    else $error("enable has extra bits");
  a_ref_width: assert property (i_rd && i_addr[5:0] == `QPD_OFS_REF_CTRL |=> o_rdata[31:2] == '0)
    else $error("reference control too wide");
  a_active_off: assert property (s_disable_write |=> ##[0:1] !o_active) else $error("still active");
  a_stream_pair: assert property (s_dual_count |=> o_stream_data == o_rdata[15:0]
    && o_stream_upper == o_rdata[31:16]) else $error("stream halves differ");
  a_start_idle: assert property ($rose(i_rst_n) |-> !o_active) else $error("active out of reset");
endmodule : qpd_top_assertions
bind qpd_top qpd_top_assertions #(.NUM_LINES(NUM_LINES)) u_qpd_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_lines(i_lines), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_stream_active(i_stream_active), .i_stream_rd(i_stream_rd), .i_stream_ofs(i_stream_ofs),
  .o_stream_data(o_stream_data), .o_stream_upper(o_stream_upper), .o_active(o_active));

// ---- verif/tb_qpd_top.sv ----
// Self-checking bench for the quadrature position decoder
`timescale 1ns/10ps
`include "qpd_regs.svh"
module tb_qpd_top;
  import qpd_pkg::*;
  localparam int STEP = 24;
  logic i_ref_clk, i_rst_n, i_wr, i_rd, i_stream_active, i_stream_rd;
  logic [7:0] i_addr;
  qpd_ofs_t i_stream_ofs;
  qpd_word_t i_wdata, o_rdata, rv;
  logic [15:0] o_stream_data, o_stream_upper;
  logic o_active;
  wire logic [7:0] lines;
  int errors, checks_done;
  qpd_encoder_model ENC (.i_clk(i_ref_clk), .o_lines(lines));
  // Short service count keeps each edge service to 8 cycles
  qpd_top #(.SERVICE_CYC(8)) DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_lines(lines), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_stream_active(i_stream_active), .i_stream_rd(i_stream_rd), .i_stream_ofs(i_stream_ofs),
    .o_stream_data(o_stream_data), .o_stream_upper(o_stream_upper), .o_active(o_active));
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [7:0] ad(input logic odd, input qpd_ofs_t o);
    return {1'b0, odd, o};
  endfunction : ad
  task automatic chk(input string what, input qpd_word_t exp, input qpd_word_t got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input qpd_word_t d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output qpd_word_t d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [7:0] a, input qpd_word_t exp);
    rd(a, rv);
    chk(what, exp, rv);
  endtask : rchk
  task automatic both(input qpd_ofs_t o, input qpd_word_t d);
    wr(ad(1'b0, o), d);
    wr(ad(1'b1, o), d);
  endtask : both
  task automatic steps(input logic up, input int n, input qpd_word_t exp);
    repeat (n) ENC.step(up, STEP);
    rchk("count", ad(1'b0, `QPD_OFS_COUNT), exp);
  endtask : steps
  task automatic t_regs;
    rchk("enable", ad(1'b0, `QPD_OFS_ENABLE), '0);
    wr(ad(1'b0, `QPD_OFS_SELECT), `QPD_FEATURE_QUAD);
    rchk("select", ad(1'b0, `QPD_OFS_SELECT), `QPD_FEATURE_QUAD);
    wr(ad(1'b0, `QPD_OFS_OPTIONS), 32'hFFFFFFFF);
    rchk("options", ad(1'b0, `QPD_OFS_OPTIONS), '0);
    rchk("unmapped", ad(1'b0, 6'h3C), '0);
    wr(ad(1'b1, `QPD_OFS_REF_CTRL), 32'h3);
    rchk("ref ctrl", ad(1'b1, `QPD_OFS_REF_CTRL), 32'h3);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_count;
    both(`QPD_OFS_ENABLE, '0);
    both(`QPD_OFS_SELECT, `QPD_FEATURE_QUAD);
    both(`QPD_OFS_REF_CTRL, 32'h0);
    both(`QPD_OFS_REF_LINE, 32'h5);
    both(`QPD_OFS_ENABLE, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("active", 32'h1, {31'h0, o_active});
    steps(1'b1, 4, 32'h4);
    steps(1'b0, 6, 32'hFFFFFFFE);
    rchk("float", ad(1'b0, `QPD_OFS_COUNT_F), 32'hC0000000);
    rchk("odd count", ad(1'b1, `QPD_OFS_COUNT), '0);
    // Stream read beside a bus read of the same count
    @(posedge i_ref_clk);
    i_stream_rd <= 1'b1;
    i_stream_ofs <= `QPD_OFS_COUNT;
    i_rd <= 1'b1;
    i_addr <= ad(1'b0, `QPD_OFS_COUNT);
    @(posedge i_ref_clk);
    i_stream_rd <= 1'b0;
    i_rd <= 1'b0;
    #1 chk("stream low", 32'hFFFE, {16'h0, o_stream_data});
    chk("stream upper", 32'hFFFF, {16'h0, o_stream_upper});
    chk("bus beside stream", 32'hFFFFFFFE, o_rdata);
    rchk("upper capture", ad(1'b0, `QPD_OFS_UPPER), 32'h0000FFFF);
    @(posedge i_ref_clk);
    i_stream_active <= 1'b1;
    ENC.step(1'b1, STEP);
    rchk("paused", ad(1'b0, `QPD_OFS_COUNT), 32'hFFFFFFFE);
    @(posedge i_ref_clk);
    i_stream_active <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    rchk("resumed", ad(1'b0, `QPD_OFS_COUNT), 32'hFFFFFFFF);
    $display("t_count done");
  endtask : t_count
  task automatic t_error;
    ENC.step(1'b1, 2);
    ENC.step(1'b1, 3 * STEP);
    rchk("stale errors", ad(1'b0, `QPD_OFS_ERRORS), '0);
    rchk("count kept", ad(1'b0, `QPD_OFS_COUNT), 32'hFFFFFFFF);
    rchk("jump error", ad(1'b0, `QPD_OFS_ERRORS), 32'h1);
    // Same line toggles back while its edge is still pending
    ENC.step(1'b1, 2);
    ENC.step(1'b0, 3 * STEP);
    rchk("count kept", ad(1'b0, `QPD_OFS_COUNT), 32'hFFFFFFFF);
    rchk("lost edge", ad(1'b0, `QPD_OFS_ERRORS), 32'h2);
    $display("t_error done");
  endtask : t_error
  task automatic t_ref;
    rd(ad(1'b0, `QPD_OFS_COUNT_RC), rv);
    rchk("cleared", ad(1'b0, `QPD_OFS_COUNT), '0);
    both(`QPD_OFS_REF_CTRL, 32'h1);
    ENC.set_ref(1'b1);
    steps(1'b1, 2, '0);
    ENC.set_ref(1'b0);
    steps(1'b1, 1, 32'h1);
    both(`QPD_OFS_REF_CTRL, 32'h3);
    rchk("read clear", ad(1'b0, `QPD_OFS_COUNT_RC), 32'h1);
    ENC.set_ref(1'b1);
    steps(1'b1, 1, '0);
    steps(1'b1, 2, 32'h2);
    ENC.set_ref(1'b0);
    rchk("read clear", ad(1'b0, `QPD_OFS_COUNT_RC), 32'h2);
    steps(1'b1, 1, 32'h1);
    ENC.set_ref(1'b1);
    steps(1'b1, 1, '0);
    ENC.set_ref(1'b0);
    steps(1'b1, 1, 32'h1);
    ENC.noise(5'h1F);
    repeat (STEP) @(posedge i_ref_clk);
    rchk("other lines", ad(1'b0, `QPD_OFS_COUNT) | 8'h80, 32'h1);
    wr(ad(1'b0, `QPD_OFS_ENABLE), '0);
    rchk("inactive", ad(1'b0, `QPD_OFS_ENABLE), '0);
    wr(ad(1'b0, `QPD_OFS_ENABLE), 32'h1);
    rchk("restart", ad(1'b0, `QPD_OFS_COUNT), '0);
    $display("t_ref done");
  endtask : t_ref
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    {i_rst_n, i_wr, i_rd, i_stream_active, i_stream_rd} = '0;
    i_addr = '0;
    i_wdata = '0;
    i_stream_ofs = '0;
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_count();
    t_error();
    t_ref();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    stop_test();
  end
endmodule : tb_qpd_top

// ---- verilog/qpd_top.sv ----
// Quadrature position decoder for one even/odd line pair with register port
//
// Contract
// - Pair is adjacent even/odd lines; even is phase A, odd is phase B.
// - Every rising and falling edge on either phase moves the count by one.
// - Enable setting: 0 disables, 1 enables the feature.
// - Reference control: 0 off, 1 continuous, 3 one-shot reference reset.
// - Count zeroes when reference line is high at any phase edge.
// - One-shot zeroes once; rearmed by re-enable or read-and-clear.
// - Count reads as signed two's complement integer.
// - Error count reports decoding errors since the feature was set up.
// - Float result gives the same count as single precision.
// - Results live on the even line; odd line results read zero.
// - Only integer or float count reads take a new snapshot; streamed float reads take none here.
// - Read-and-clear returns the count, then zeroes it.
// - Streamed integer reads give low 16 bits; upper half captured separately.
// - Two edges too close for service count as a decoding error.
// - Three close edges may give an undetected counting error.
// - One edge service takes 14 us, runs alone, stream may pause it.
// - Edge sets line pending flag; cleared at service end; edges meanwhile lost.
// - Both edge polarities on each line are serviced.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "qpd_regs.svh"

module qpd_top #(
  parameter int NUM_LINES = 8,
  parameter int PAIR_BASE = 6,
  parameter int SERVICE_CYC = `QPD_SERVICE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [NUM_LINES-1:0] i_lines,
  input wire logic [7:0] i_addr,
  input wire qpd_pkg::qpd_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output qpd_pkg::qpd_word_t o_rdata,
  input wire logic i_stream_active,
  input wire logic i_stream_rd,
  input wire qpd_pkg::qpd_ofs_t i_stream_ofs,
  output logic [15:0] o_stream_data,
  output logic [15:0] o_stream_upper,
  output logic o_active
);
  import qpd_pkg::*;

  localparam int LW = $clog2(NUM_LINES);
  localparam int CW = $clog2(SERVICE_CYC);
  localparam int PA = PAIR_BASE;
  localparam int PB = PAIR_BASE + 1;

  generate
    if ((PAIR_BASE % 2) != 0 || PB >= NUM_LINES || SERVICE_CYC < 2 || NUM_LINES < 2) begin : g_bad_cfg
      $error("qpd_top: pair must be an even/odd pair inside the lines, service at least 2 cycles");
    end
  endgenerate

  // Rounds toward zero; a 32-bit count can exceed the 24-bit mantissa
  function automatic qpd_word_t to_float(input qpd_word_t v);
    qpd_word_t mag;
    qpd_word_t norm;
    logic [4:0] msb;
    logic [7:0] expo;
    mag = v[31] ? (~v + 32'h00000001) : v;
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    norm = mag << (5'h1F - msb);
    expo = 8'h7F + {3'h0, msb};
    to_float = (mag == 32'h00000000) ? 32'h00000000 : {v[31], expo, norm[30:8]};
  endfunction : to_float

  function automatic qpd_word_t result_mux(input qpd_ofs_t ofs, input qpd_word_t cnt, input qpd_word_t errs,
                                           input qpd_word_t flt, input logic [15:0] upper);
    if (ofs == `QPD_OFS_COUNT || ofs == `QPD_OFS_COUNT_RC) begin
      result_mux = cnt;
    end else if (ofs == `QPD_OFS_ERRORS) begin
      result_mux = errs;
    end else if (ofs == `QPD_OFS_COUNT_F) begin
      result_mux = flt;
    end else if (ofs == `QPD_OFS_UPPER) begin
      result_mux = {16'h0000, upper};
    end else begin
      result_mux = 32'h00000000;
    end
  endfunction : result_mux

  // Pin synchronisers: a change counts once stages two and three agree
  logic [NUM_LINES-1:0] sync1_r, sync2_r, sync3_r, stable_r, stable_nxt;
  wire [NUM_LINES-1:0] agree = ~(sync2_r ^ sync3_r);
  assign stable_nxt = (agree & sync3_r) | (~agree & stable_r);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      stable_r <= '0;
    end else begin
      sync1_r <= i_lines;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      stable_r <= stable_nxt;
    end
  end

  // Any change, either polarity, is an edge to service
  wire edge_a = stable_nxt[PA] != stable_r[PA];
  wire edge_b = stable_nxt[PB] != stable_r[PB];
  wire [1:0] edges = {edge_b, edge_a};
  wire [1:0] ab_now = {stable_r[PA], stable_r[PB]};

  // Register port decode
  wire line_odd = i_addr[`QPD_LINE_BIT];
  wire [5:0] ofs = i_addr[5:0];
  wire [1:0] wr_line = {i_wr & line_odd, i_wr & ~line_odd};

  logic [1:0] en_r;
  qpd_word_t sel_r [2];
  logic [1:0] refc_r [2];
  qpd_word_t refl_r [2];
  qpd_word_t cfg_word [2];

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_line
      wire wr_en = wr_line[gl] && ofs == `QPD_OFS_ENABLE;
      wire wr_sel = wr_line[gl] && ofs == `QPD_OFS_SELECT;
      wire wr_refc = wr_line[gl] && ofs == `QPD_OFS_REF_CTRL;
      wire wr_refl = wr_line[gl] && ofs == `QPD_OFS_REF_LINE;

      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          en_r[gl] <= 1'b0;
          sel_r[gl] <= `QPD_RST_WORD;
          refc_r[gl] <= `QPD_REF_OFF;
          refl_r[gl] <= `QPD_RST_WORD;
        end else begin
          if (wr_en) en_r[gl] <= i_wdata[0];
          if (wr_sel) sel_r[gl] <= i_wdata;
          if (wr_refc) refc_r[gl] <= i_wdata[1:0];
          if (wr_refl) refl_r[gl] <= i_wdata;
        end
      end

      // Options and spare settings are unused and read zero
      assign cfg_word[gl] = (ofs == `QPD_OFS_ENABLE) ? {31'h00000000, en_r[gl]} :
                            (ofs == `QPD_OFS_SELECT) ? sel_r[gl] :
                            (ofs == `QPD_OFS_REF_CTRL) ? {30'h00000000, refc_r[gl]} :
                            (ofs == `QPD_OFS_REF_LINE) ? refl_r[gl] : 32'h00000000;
    end
  endgenerate

  // Decoder runs only with both lines enabled on the quadrature feature
  wire active_now = &en_r && sel_r[0] == `QPD_FEATURE_QUAD && sel_r[1] == `QPD_FEATURE_QUAD;
  logic active_r;
  wire act_rise = active_now & ~active_r;

  // Even line's reference settings govern; host keeps both identical
  wire [1:0] ref_mode = refc_r[0];
  wire ref_cont = ref_mode == `QPD_REF_CONT;
  wire ref_once = ref_mode == `QPD_REF_ONESHOT;
  wire ref_in_range = refl_r[0] < 32'(NUM_LINES);
  wire ref_lvl = ref_in_range & stable_r[refl_r[0][LW-1:0]];

  // Result state
  qpd_word_t count_r, count_nxt, err_r, err_nxt, err_snap_r;
  logic [15:0] upper_r;
  wire qpd_word_t count_f = to_float(count_r);

  // Reads and their side effects
  wire rd_even = i_rd & ~line_odd;
  wire bus_cnt_rd = rd_even && (ofs == `QPD_OFS_COUNT || ofs == `QPD_OFS_COUNT_F || ofs == `QPD_OFS_COUNT_RC);
  wire bus_rc = rd_even && ofs == `QPD_OFS_COUNT_RC;
  wire st_cnt_rd = i_stream_rd && (i_stream_ofs == `QPD_OFS_COUNT || i_stream_ofs == `QPD_OFS_COUNT_RC);
  wire st_int_rd = st_cnt_rd || (i_stream_rd && i_stream_ofs == `QPD_OFS_ERRORS);
  wire st_rc = i_stream_rd && i_stream_ofs == `QPD_OFS_COUNT_RC;
  wire snap = bus_cnt_rd | st_cnt_rd;
  wire clear_rc = bus_rc | st_rc;

  wire qpd_word_t res_bus = result_mux(ofs, count_r, err_snap_r, count_f, upper_r);
  wire qpd_word_t res_st = result_mux(i_stream_ofs, count_r, err_snap_r, count_f, upper_r);
  // Odd line shows its settings but never results
  wire qpd_word_t rd_word = line_odd ? cfg_word[1] : (cfg_word[0] | res_bus);

  // Edge service engine: one routine at a time, stream activity pauses it
  qpd_svc_t state_r;
  logic svc_ch_r;
  logic [CW-1:0] svc_cnt_r;
  logic [1:0] pend_r;
  logic [1:0] last_ab_r;
  logic z_hit_r;
  logic armed_r;

  wire svc_busy = state_r == QPD_SERVICE;
  wire start = !svc_busy && active_r && |pend_r;
  wire start_ch = ~pend_r[0];
  wire done = svc_busy && !i_stream_active && svc_cnt_r == CW'(SERVICE_CYC - 1);
  wire [1:0] done_mask = {done & svc_ch_r, done & ~svc_ch_r};
  wire [1:0] lost = edges & pend_r & ~done_mask;
  wire [1:0] pend_nxt = active_r ? (edges | (pend_r & ~done_mask)) : 2'h0;

  // Gray step check against the state left by the previous routine
  wire [1:0] delta = ab_now ^ last_ab_r;
  wire moved = |delta;
  // Three close edges can look like one legal step and pass unseen
  wire jump = &delta;
  wire step_up = last_ab_r[0] ^ ab_now[1];

  wire z_set = active_r && (edge_a | edge_b) && ref_lvl && (ref_cont | ref_once);
  wire z_fire = done && z_hit_r && (ref_cont || (ref_once && armed_r));

  always_comb begin
    if (!active_now || act_rise || clear_rc) begin
      count_nxt = 32'h00000000;
    end else if (z_fire) begin
      count_nxt = 32'h00000000;
    end else if (done && moved && !jump) begin
      count_nxt = step_up ? count_r + 32'h00000001 : count_r - 32'h00000001;
    end else begin
      count_nxt = count_r;
    end
  end

  // Lost edges and double jumps both add to the error tally
  always_comb begin
    if (!active_now || act_rise) begin
      err_nxt = 32'h00000000;
    end else begin
      err_nxt = err_r + {31'h00000000, lost[0]} + {31'h00000000, lost[1]} + {31'h00000000, done & jump};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      active_r <= 1'b0;
      count_r <= 32'h00000000;
      err_r <= 32'h00000000;
    end else begin
      active_r <= active_now;
      count_r <= count_nxt;
      err_r <= err_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= QPD_IDLE;
      svc_ch_r <= 1'b0;
      svc_cnt_r <= '0;
    end else if (!active_r) begin
      state_r <= QPD_IDLE;
      svc_cnt_r <= '0;
    end else begin
      unique case (state_r)
        QPD_IDLE: begin
          if (start) begin
            state_r <= QPD_SERVICE;
            svc_ch_r <= start_ch;
            svc_cnt_r <= '0;
          end
        end
        QPD_SERVICE: begin
          if (done) begin
            state_r <= QPD_IDLE;
          end else if (!i_stream_active) begin
            svc_cnt_r <= svc_cnt_r + CW'(1);
          end
        end
      endcase
    end
  end

  // Set wins over clear on pending and reference flags
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pend_r <= 2'h0;
      z_hit_r <= 1'b0;
      armed_r <= 1'b0;
      last_ab_r <= 2'h0;
    end else begin
      pend_r <= act_rise ? 2'h0 : pend_nxt;
      z_hit_r <= active_r & ~act_rise & (z_set | (z_hit_r & ~done));
      if (act_rise || clear_rc) begin
        armed_r <= 1'b1;
      end else if (z_fire && ref_once) begin
        armed_r <= 1'b0;
      end
      if (act_rise || done) last_ab_r <= ab_now;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      err_snap_r <= 32'h00000000;
      upper_r <= 16'h0000;
    end else begin
      if (snap) err_snap_r <= err_r;
      if (st_int_rd) upper_r <= res_st[31:16];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
      o_stream_data <= 16'h0000;
      o_stream_upper <= 16'h0000;
      o_active <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_word : 32'h00000000;
      o_stream_data <= i_stream_rd ? res_st[15:0] : 16'h0000;
      if (st_int_rd) o_stream_upper <= res_st[31:16];
      o_active <= active_now;
    end
  end

endmodule : qpd_top
